// ==== rtl/fsmp_port.sv ====
// Shared-pad Flash/SDRAM memory port with AHB-Lite configuration slave.
// Assumes pad inputs come from outside the clock domain; requests and the
// bus come from logic on mclk_i.
//
// Our own choices: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/1ps

// Contract
// (RL1) After reset fetch from Flash only, with slowest access timing.
// (RL2) 16-bit devices: address bit 0 is the lowest word address bit.
// (RL3) 32-bit devices: address bit 1 is the lowest word address bit.
// (RL4) Active-low byte enables select written bytes on partial writes.
// (RL5) SDRAM gets multiplexed row/column/bank; Flash gets plain address.
// (RL6) Flash uses 20 address lines, 16 data lines, 16 Mbit.
// (RL7) No Flash bursts; synchronous Flash used asynchronously only.
// (RL8) SDRAM up to 256 Mbit, 16 or 32 data lines, 100 MHz.
// (RL9) Two configurations: separate 16-bit buses or merged 32-bit bus.
// (RL10) Address translator keeps SDRAM wiring same for both widths.
// (RL11) SDRAM clock polarity selectable by configuration.
// (RL12) SDRAM clock from system clock or delay-locked clock.
// (RL13) Low-power control puts SDRAM into reduced-power state.
// (RL14) Port and SDRAM share one frequency, 100 MHz at full speed.
// (RL15) Above 70 MHz the delay-locked clock must be used.
// (RL16) Clock feedback loop closed inside or outside via input pad.
// (RL17) SDRAM outputs launch on rising or falling clock edge.
// (RL18) Memory type, size, width, latencies set by internal registers.
// (RL19) Software should not change configuration after boot programming.
// (RL20) Never access Flash and SDRAM at the same time.
// (RL21) SDRAM bank on lines 15,16; row/column on lines 0 to 11.
// (RL22) Reset restores slow Flash-only defaults, delay-locked clock off.
module fsmp_port (
    input  wire logic        mclk_i,
    input  wire logic        rst_n_i,
    input  wire logic        ce_i,
    input  wire logic        hsel_i,
    input  wire logic [31:0] haddr_i,
    input  wire logic [1:0]  htrans_i,
    input  wire logic        hwrite_i,
    input  wire logic [2:0]  hsize_i,
    input  wire logic [31:0] hwdata_i,
    input  wire logic        hready_i,
    output logic             hreadyout_o,
    output logic             hresp_o,
    output logic [31:0]      hrdata_o,
    input  wire logic        req_valid_i,
    output logic             req_ready_o,
    input  wire logic [24:0] req_addr_i,
    input  wire logic        req_write_i,
    input  wire logic        req_sdram_i,
    input  wire logic [31:0] req_wdata_i,
    input  wire logic [3:0]  req_be_i,
    output logic             resp_valid_o,
    output logic [31:0]      resp_rdata_o,
    output logic [19:0]      addr_o,
    output logic             flash_cs_n_o,
    output logic             sdram_cs_n_o,
    output logic             ras_n_o,
    output logic             cas_n_o,
    output logic             rd_not_wr_o,
    output logic [1:0]       byte_enable_n_o,
    output logic             sdram_cke_o,
    input  wire logic [15:0] flash_d_i,
    output logic [15:0]      flash_d_o,
    output logic             flash_d_oe_o,
    input  wire logic [15:0] sdram_d_i,
    output logic [15:0]      sdram_d_o,
    output logic             sdram_d_oe_o,
    input  wire logic        dll_clk_i,
    input  wire logic        dll_locked_i,
    input  wire logic        ckin_sdram_i,
    output logic             dll_fb_ext_o,
    output logic             sdram_clk_o
);
    logic [31:0]            ctrl_reg;
    logic [6:0]             tac_reg;
    logic [3:0]             tbr_reg;
    logic [6:0]             freq_reg;
    logic                   ah_wr_reg;
    logic [7:0]             ah_ofs_reg;
    fsmp_pkg::fsmp_state_e  state_reg;
    fsmp_pkg::fsmp_req_s    req_reg;
    fsmp_pkg::fsmp_pad_s    pad_reg;
    fsmp_pkg::fsmp_pad_s    pad_next;
    fsmp_pkg::fsmp_pad_s    pad_fall_reg;
    logic [7:0]             cnt_reg;
    logic [31:0]            rdata_reg;
    logic                   resp_reg;
    logic [1:0][15:0]       fl_sync_reg;
    logic [1:0][15:0]       sd_sync_reg;
    logic [2:0]             ck_sync_reg;
    logic [1:0]             lock_sync_reg;
    logic [7:0]             fb_edges_reg;
    logic                   cfg_sd_en;
    logic                   cfg_bus32;
    logic                   dll_use;
    logic                   sd_lowpwr;
    logic                   sd_go;
    logic [4:0]             col_bits;
    logic [23:0]            sd_word;
    logic [11:0]            sd_col;
    logic [11:0]            sd_row;
    logic [1:0]             sd_bank;
    logic                   half_hi;
    logic [15:0]            wr_half;
    logic [1:0]             be_half;
    logic [19:0]            sd_row_pins;
    logic [19:0]            sd_col_pins;

    assign cfg_sd_en = ctrl_reg[fsmp_pkg::CTL_SD_EN];
    assign cfg_bus32 = ctrl_reg[fsmp_pkg::CTL_BUS32];
    assign sd_lowpwr = ctrl_reg[fsmp_pkg::CTL_LOWPWR];
    // Forced delay-locked clock above 70 MHz
    assign dll_use = ctrl_reg[fsmp_pkg::CTL_DLL_SEL]
                   | (freq_reg > fsmp_pkg::DLL_MIN_MHZ);  // RL15 RL12
    assign dll_fb_ext_o = ctrl_reg[fsmp_pkg::CTL_FB_EXT];  // RL16
    // Same-frequency SDRAM clock, polarity selectable
    assign sdram_clk_o = (dll_use ? dll_clk_i : mclk_i)
                       ^ ctrl_reg[fsmp_pkg::CTL_CK_POL];  // RL11 RL14 RL8

    // AHB-Lite slave, zero wait states, always OKAY
    assign hreadyout_o = 1'b1;
    assign hresp_o     = 1'b0;

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            ah_wr_reg  <= 1'b0;
            ah_ofs_reg <= 8'h00;
        end else if (ce_i && hready_i) begin
            ah_wr_reg  <= hsel_i & htrans_i[1] & hwrite_i;
            ah_ofs_reg <= haddr_i[7:0];
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            ctrl_reg <= fsmp_pkg::CTRL_RST;                      // RL22 RL1
            tac_reg  <= fsmp_pkg::TAC_RST;
            tbr_reg  <= fsmp_pkg::TBR_RST;
            freq_reg <= fsmp_pkg::FREQ_RST;
        end else if (ce_i && ah_wr_reg) begin                    // RL18
            case (ah_ofs_reg)
                fsmp_pkg::OFS_CTRL: ctrl_reg <= {13'h0000, hwdata_i[18:0]};
                fsmp_pkg::OFS_FTIM: begin
                    tac_reg <= (hwdata_i[6:0] < 7'h02) ? 7'h02
                                                       : hwdata_i[6:0];
                    tbr_reg <= hwdata_i[11:8];
                end
                fsmp_pkg::OFS_FREQ: freq_reg <= hwdata_i[6:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            hrdata_o <= 32'h0000_0000;
        end else if (ce_i && hready_i) begin
            hrdata_o <= 32'h0000_0000;
            if (hsel_i && htrans_i[1] && !hwrite_i) begin
                case (haddr_i[7:0])
                    fsmp_pkg::OFS_CTRL: hrdata_o <= ctrl_reg;
                    fsmp_pkg::OFS_FTIM:
                        hrdata_o <= {20'h0_0000, tbr_reg, 1'b0, tac_reg};
                    fsmp_pkg::OFS_FREQ: hrdata_o <= {25'h000_0000, freq_reg};
                    fsmp_pkg::OFS_STATUS:
                        hrdata_o <= {16'h0000, fb_edges_reg, 4'h0,
                                     sd_lowpwr, dll_use, lock_sync_reg[1],
                                     state_reg != fsmp_pkg::ST_IDLE};
                    default: hrdata_o <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Pad input synchronisers and feedback clock edge count
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            fl_sync_reg   <= '0;
            sd_sync_reg   <= '0;
            ck_sync_reg   <= 3'h0;
            lock_sync_reg <= 2'h0;
        end else if (ce_i) begin
            fl_sync_reg   <= {fl_sync_reg[0], flash_d_i};
            sd_sync_reg   <= {sd_sync_reg[0], sdram_d_i};
            ck_sync_reg   <= {ck_sync_reg[1:0], ckin_sdram_i};
            lock_sync_reg <= {lock_sync_reg[0], dll_locked_i};
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            fb_edges_reg <= 8'h00;
        end else if (ce_i && ctrl_reg[fsmp_pkg::CTL_FB_EXT]
                     && ck_sync_reg[1] && !ck_sync_reg[2]) begin  // RL16
            fb_edges_reg <= fb_edges_reg + 8'h01;
        end
    end

    // Address forming for SDRAM
    assign col_bits = 5'h08 + {3'h0, ctrl_reg[fsmp_pkg::CTL_COL_LO +: 2]};
    assign sd_word  = cfg_bus32 ? {1'b0, req_reg.addr[24:2]}
                                : req_reg.addr[24:1];            // RL2 RL3
    assign sd_col   = 12'((sd_word << (5'd24 - col_bits)) >> (5'd24 - col_bits));
    assign sd_row   = 12'(sd_word >> col_bits);
    assign sd_bank  = 2'(sd_word >> (col_bits + 5'h0C));
    assign half_hi  = req_reg.addr[1];
    assign wr_half  = half_hi ? req_reg.wdata[31:16] : req_reg.wdata[15:0];
    assign be_half  = half_hi ? req_reg.be[3:2] : req_reg.be[1:0];

    // Translator: merged bus without it presents words from line 1
    function automatic logic [19:0] sd_pins(input logic [11:0] a,
                                            input logic [1:0]  bank,
                                            input logic [3:0]  be,
                                            input logic        bus32,
                                            input logic        xl);
        logic [19:0] p;
        p = 20'h0_0000;
        if (bus32 && !xl) begin
            p[12:1] = a;                                         // RL3
        end else begin
            p[11:0] = a;                                         // RL10 RL2
        end
        p[fsmp_pkg::PAD_BANK_LO +: 2] = bank;                    // RL21
        if (bus32) begin
            p[fsmp_pkg::PAD_BE32_LO +: 2] = ~be[1:0];            // RL4
        end
        return p;
    endfunction : sd_pins

    assign sd_row_pins = sd_pins(sd_row, sd_bank, 4'hF, cfg_bus32,
                                 ctrl_reg[fsmp_pkg::CTL_XLATE]);
    assign sd_col_pins = sd_pins(sd_col, sd_bank, req_reg.be, cfg_bus32,
                                 ctrl_reg[fsmp_pkg::CTL_XLATE]);

    // SDRAM held off during boot, Flash used instead; in low power SDRAM requests wait
    assign sd_go       = req_sdram_i & cfg_sd_en;               // RL1
    assign req_ready_o = (state_reg == fsmp_pkg::ST_IDLE)
                       & ~(sd_go & sd_lowpwr);                   // RL13

    // Access sequencer: one memory at a time, single accesses only
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            state_reg <= fsmp_pkg::ST_IDLE;
            req_reg   <= '0;
            cnt_reg   <= 8'h00;
            rdata_reg <= 32'h0000_0000;
            resp_reg  <= 1'b0;
        end else if (ce_i) begin
            resp_reg <= 1'b0;
            case (state_reg)
                fsmp_pkg::ST_IDLE: begin
                    if (req_valid_i && req_ready_o) begin        // RL20
                        req_reg <= '{addr: req_addr_i, write: req_write_i,
                                     to_sdram: sd_go, wdata: req_wdata_i,
                                     be: req_be_i};
                        cnt_reg <= 8'h00;
                        state_reg <= sd_go ? fsmp_pkg::ST_SD_ACT
                                           : fsmp_pkg::ST_FL_ACC;
                    end
                end
                fsmp_pkg::ST_FL_ACC: begin                       // RL7
                    cnt_reg <= cnt_reg + 8'h01;
                    if (cnt_reg == {1'b0, tac_reg} - 8'h01) begin
                        rdata_reg <= {fl_sync_reg[1], fl_sync_reg[1]};
                        cnt_reg   <= 8'h00;
                        state_reg <= fsmp_pkg::ST_FL_REL;
                    end
                end
                fsmp_pkg::ST_FL_REL: begin
                    cnt_reg <= cnt_reg + 8'h01;
                    if (cnt_reg >= {4'h0, tbr_reg}) begin
                        state_reg <= fsmp_pkg::ST_DONE;
                    end
                end
                fsmp_pkg::ST_SD_ACT: begin
                    cnt_reg <= cnt_reg + 8'h01;
                    if (cnt_reg >= {5'h00, ctrl_reg[fsmp_pkg::CTL_RCD_LO +: 3]})
                    begin
                        cnt_reg   <= 8'h00;
                        state_reg <= fsmp_pkg::ST_SD_CMD;
                    end
                end
                fsmp_pkg::ST_SD_CMD: begin
                    state_reg <= req_reg.write ? fsmp_pkg::ST_DONE
                                               : fsmp_pkg::ST_SD_LAT;
                end
                fsmp_pkg::ST_SD_LAT: begin
                    cnt_reg <= cnt_reg + 8'h01;
                    if (cnt_reg == {5'h00, ctrl_reg[fsmp_pkg::CTL_CAS_LO +: 3]}
                                   + 8'(fsmp_pkg::SYNC_LAT)) begin
                        rdata_reg <= cfg_bus32
                            ? {sd_sync_reg[1], fl_sync_reg[1]}   // RL9
                            : {sd_sync_reg[1], sd_sync_reg[1]};
                        state_reg <= fsmp_pkg::ST_DONE;
                    end
                end
                fsmp_pkg::ST_DONE: begin
                    resp_reg  <= 1'b1;
                    state_reg <= fsmp_pkg::ST_IDLE;
                end
                default: state_reg <= fsmp_pkg::ST_IDLE;
            endcase
        end
    end

    assign resp_valid_o = resp_reg;
    assign resp_rdata_o = rdata_reg;

    // Pad values for the coming cycle
    always_comb begin
        pad_next     = fsmp_pkg::PAD_IDLE;
        pad_next.cke = ~sd_lowpwr;                               // RL13
        case (state_reg)
            fsmp_pkg::ST_FL_ACC, fsmp_pkg::ST_FL_REL: begin
                pad_next.addr = req_reg.addr[20:1];              // RL6 RL5
                pad_next.flash_cs_n = (state_reg != fsmp_pkg::ST_FL_ACC);
                pad_next.rd_not_wr  = ~req_reg.write;
                pad_next.cas_n = req_reg.write
                               | (state_reg != fsmp_pkg::ST_FL_ACC);
                pad_next.byte_enable_n = ~be_half;               // RL4
                pad_next.flash_dq = wr_half;
                pad_next.flash_oe = req_reg.write
                                  & (state_reg == fsmp_pkg::ST_FL_ACC);
            end
            fsmp_pkg::ST_SD_ACT: begin
                pad_next.addr       = sd_row_pins;               // RL5 RL21
                pad_next.sdram_cs_n = (cnt_reg != 8'h00);
                pad_next.ras_n      = (cnt_reg != 8'h00);
            end
            fsmp_pkg::ST_SD_CMD: begin
                pad_next.addr       = sd_col_pins;
                pad_next.sdram_cs_n = 1'b0;
                pad_next.cas_n      = 1'b0;
                pad_next.rd_not_wr  = ~req_reg.write;
                if (cfg_bus32) begin
                    pad_next.byte_enable_n = ~req_reg.be[3:2];   // RL4 RL9
                    pad_next.flash_dq = req_reg.wdata[15:0];
                    pad_next.sdram_dq = req_reg.wdata[31:16];
                    pad_next.flash_oe = req_reg.write;
                end else begin
                    pad_next.byte_enable_n = ~be_half;
                    pad_next.sdram_dq = wr_half;
                end
                pad_next.sdram_oe = req_reg.write;
            end
            default: ;
        endcase
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            pad_reg <= fsmp_pkg::PAD_IDLE;
        end else if (ce_i) begin
            pad_reg <= pad_next;
        end
    end

    // Half-cycle later copy for falling-edge launch
    always_ff @(negedge mclk_i) begin
        if (!rst_n_i) begin
            pad_fall_reg <= fsmp_pkg::PAD_IDLE;
        end else if (ce_i) begin
            pad_fall_reg <= pad_reg;
        end
    end

    fsmp_pkg::fsmp_pad_s pad_out;
    assign pad_out = ctrl_reg[fsmp_pkg::CTL_FALL] ? pad_fall_reg
                                                  : pad_reg;      // RL17
    assign addr_o          = pad_out.addr;
    assign flash_cs_n_o    = pad_out.flash_cs_n;
    assign sdram_cs_n_o    = pad_out.sdram_cs_n;
    assign ras_n_o         = pad_out.ras_n;
    assign cas_n_o         = pad_out.cas_n;
    assign rd_not_wr_o     = pad_out.rd_not_wr;
    assign byte_enable_n_o = pad_out.byte_enable_n;
    assign sdram_cke_o     = pad_out.cke;
    assign flash_d_o       = pad_out.flash_dq;
    assign flash_d_oe_o    = pad_out.flash_oe;
    assign sdram_d_o       = pad_out.sdram_dq;
    assign sdram_d_oe_o    = pad_out.sdram_oe;

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);

    chk_cs_exclusive: assert property ( // RL20
        !(!pad_reg.flash_cs_n && !pad_reg.sdram_cs_n))
        else $error("Flash and SDRAM selected together");
    chk_boot_flash_only: assert property ( // RL1
        !cfg_sd_en |-> pad_reg.sdram_cs_n)
        else $error("SDRAM selected before enable");
    chk_reset_defaults: assert property ( // RL22
        $rose(rst_n_i) |-> ctrl_reg == fsmp_pkg::CTRL_RST
                           && tac_reg == fsmp_pkg::TAC_RST && !dll_use)
        else $error("Boot defaults not restored");
    chk_flash_plain_addr: assert property ( // RL5
        ce_i && state_reg == fsmp_pkg::ST_FL_ACC
        |=> pad_reg.addr == req_reg.addr[20:1])
        else $error("Flash address not plain word address");
    chk_flash_cs_len: assert property ( // RL7
        ce_i && state_reg == fsmp_pkg::ST_IDLE && req_valid_i
        && req_ready_o && !sd_go && tac_reg == 7'h02 && $stable(tac_reg)
        ##1 ce_i[*2] |=> !pad_reg.flash_cs_n ##1 ce_i |=> pad_reg.flash_cs_n)
        else $error("Flash select length wrong");
    chk_word32_lsb: assert property ( // RL3
        ce_i && state_reg == fsmp_pkg::ST_SD_CMD && cfg_bus32
        && !ctrl_reg[fsmp_pkg::CTL_XLATE] |=> !pad_reg.addr[0])
        else $error("Merged bus address bit 0 used");
    chk_bank_lines: assert property ( // RL21
        ce_i && state_reg == fsmp_pkg::ST_SD_ACT
        |=> pad_reg.addr[16:15] == $past(sd_bank))
        else $error("Bank not on lines 15 and 16");
    chk_be_full_write: assert property ( // RL4
        ce_i && state_reg == fsmp_pkg::ST_SD_CMD && req_reg.write
        && req_reg.be == 4'hF |=> pad_reg.byte_enable_n == 2'h0)
        else $error("Byte enables wrong on full write");
    chk_lowpower_cke: assert property ( // RL13
        ce_i && sd_lowpwr |=> !pad_reg.cke)
        else $error("SDRAM clock enable not dropped");
    chk_dll_above_70: assert property ( // RL15
        freq_reg > 7'h46 |-> dll_use)
        else $error("Delay-locked clock not used above 70 MHz");
    chk_launch_edge: assert property ( // RL17
        ctrl_reg[fsmp_pkg::CTL_FALL] |-> addr_o == pad_fall_reg.addr)
        else $error("Falling-edge launch not selected");

    cov_flash_read: cover property (
        state_reg == fsmp_pkg::ST_FL_ACC && !req_reg.write);
    cov_sdram_write: cover property (
        state_reg == fsmp_pkg::ST_SD_CMD && req_reg.write);
    cov_sdram_read32: cover property (
        state_reg == fsmp_pkg::ST_SD_LAT && cfg_bus32);
    cov_lowpower_hold: cover property (
        req_valid_i && sd_go && sd_lowpwr);
endmodule : fsmp_port

// ==== include/fsmp_pkg.sv ====
// Package for the shared Flash/SDRAM memory port.
// Assumes a 100 MHz system clock that also clocks the SDRAM.
package fsmp_pkg;
    localparam int unsigned SYS_FREQ_MHZ = 100;
    localparam logic [6:0]  DLL_MIN_MHZ  = 7'h46;   // 70 MHz
    // Register byte offsets
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_FTIM   = 8'h04;
    localparam logic [7:0] OFS_FREQ   = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0C;
    // Control field positions
    localparam int CTL_SD_EN   = 0;
    localparam int CTL_BUS32   = 1;
    localparam int CTL_XLATE   = 2;
    localparam int CTL_CK_POL  = 3;
    localparam int CTL_DLL_SEL = 4;
    localparam int CTL_FB_EXT  = 5;
    localparam int CTL_FALL    = 6;
    localparam int CTL_LOWPWR  = 7;
    localparam int CTL_COL_LO  = 8;    // [9:8] column bits minus 8
    localparam int CTL_CAS_LO  = 12;   // [14:12] CAS latency
    localparam int CTL_RCD_LO  = 16;   // [18:16] row to column delay
    // Reset values: slow Flash-only boot
    localparam logic [31:0] CTRL_RST = 32'h0007_3100;
    localparam logic [6:0]  TAC_RST  = 7'h7F;     // access cycles
    localparam logic [3:0]  TBR_RST  = 4'hF;      // bus release cycles
    localparam logic [6:0]  FREQ_RST = 7'h04;
    localparam int unsigned SYNC_LAT = 2;         // input synchroniser
    // Pad field positions
    localparam int PAD_BANK_LO = 15;
    localparam int PAD_BE32_LO = 18;

    typedef struct packed {
        logic [24:0] addr;
        logic        write;
        logic        to_sdram;
        logic [31:0] wdata;
        logic [3:0]  be;
    } fsmp_req_s;

    typedef struct packed {
        logic [19:0] addr;
        logic        flash_cs_n;
        logic        sdram_cs_n;
        logic        ras_n;
        logic        cas_n;
        logic        rd_not_wr;
        logic [1:0]  byte_enable_n;
        logic [15:0] flash_dq;
        logic        flash_oe;
        logic [15:0] sdram_dq;
        logic        sdram_oe;
        logic        cke;
    } fsmp_pad_s;

    localparam fsmp_pad_s PAD_IDLE = '{addr: 20'h0_0000, flash_cs_n: 1'b1,
        sdram_cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1, rd_not_wr: 1'b1,
        byte_enable_n: 2'h3, flash_dq: 16'h0000, flash_oe: 1'b0,
        sdram_dq: 16'h0000, sdram_oe: 1'b0, cke: 1'b1};

    typedef enum logic [2:0] {
        ST_IDLE, ST_FL_ACC, ST_FL_REL, ST_SD_ACT, ST_SD_CMD, ST_SD_LAT,
        ST_DONE
    } fsmp_state_e;
endpackage : fsmp_pkg

// ==== verification/fsmp_mem_model.sv ====
// Flash and SDRAM data pads seen from the memory chips.
// Assumes the port samples these lines on its own system clock.
`timescale 1ns/1ps
module fsmp_mem_model (
    input  wire logic        mclk_i,
    input  wire logic        flash_cs_n_i,
    input  wire logic        oe_n_i,
    input  wire logic [19:0] addr_i,
    output logic      [15:0] flash_d_o,
    output logic      [15:0] sdram_d_o
);
    logic [15:0] last_reg = 16'h0000;
    logic        tgl_reg  = 1'h0;
    logic        sel;
    assign sel = !flash_cs_n_i && !oe_n_i;
    always @(posedge mclk_i) begin
        tgl_reg <= ~tgl_reg;
        if (sel) last_reg <= addr_i[15:0] ^ 16'h5A5A;
    end
    // Released bus shows the inverse of the last word
    assign flash_d_o = sel ? addr_i[15:0] ^ 16'h5A5A : ~last_reg;
    assign sdram_d_o = {16{tgl_reg}} ^ 16'h3C3C;
endmodule : fsmp_mem_model

// ==== verification/fsmp_port_tb.sv ====
// Self-checking bench for the shared Flash/SDRAM memory port.
// Assumes the design and the memory pad model are compiled first.
`timescale 1ns/1ps
module fsmp_port_tb;
    logic        mclk_i = 1'h0, rst_n_i = 1'h0, lclk = 1'h0, hsel = 1'h0;
    logic        hwrite = 1'h0, rv = 1'h0, rw = 1'h0, rs = 1'h0;
    logic        hrdy, rrdy, pv, fcs_n, scs_n, cas_n, cke;
    logic [1:0]  htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, q, hrdata, prd;
    logic [24:0] ra = 25'h0;
    logic [19:0] pa, fl_addr;
    logic [15:0] fd, sd;
    int          fail_count = 0, samples_checked = 0;
    fsmp_port i_fsmp_port (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .ce_i(1'h1),
        .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
        .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hrdy),
        .hreadyout_o(hrdy), .hresp_o(), .hrdata_o(hrdata), .req_valid_i(rv),
        .req_ready_o(rrdy), .req_addr_i(ra), .req_write_i(rw),
        .req_sdram_i(rs), .req_wdata_i(32'hA5C3_0F96), .req_be_i(4'hF),
        .resp_valid_o(pv), .resp_rdata_o(prd), .addr_o(pa),
        .flash_cs_n_o(fcs_n), .sdram_cs_n_o(scs_n), .ras_n_o(),
        .cas_n_o(cas_n), .rd_not_wr_o(), .byte_enable_n_o(),
        .sdram_cke_o(cke), .flash_d_i(fd), .flash_d_o(), .flash_d_oe_o(),
        .sdram_d_i(sd), .sdram_d_o(), .sdram_d_oe_o(), .dll_clk_i(lclk),
        .dll_locked_i(1'h1), .ckin_sdram_i(lclk), .dll_fb_ext_o(),
        .sdram_clk_o());
    fsmp_mem_model i_fsmp_mem_model (.mclk_i(mclk_i), .flash_cs_n_i(fcs_n),
        .oe_n_i(cas_n), .addr_i(pa), .flash_d_o(fd), .sdram_d_o(sd));
    initial forever #5 mclk_i = ~mclk_i;
    initial forever #62.5 lclk = ~lclk;
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic report_and_stop;
        $display("checks=%0d mismatches=%0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : report_and_stop
    task automatic look(output logic r, output logic [31:0] d, input int s);
        @(negedge mclk_i);
        r = (s == 0) ? hrdy : (s == 1) ? rrdy : pv;
        d = (s == 0) ? hrdata : prd;
        @(posedge mclk_i);
    endtask : look
    task automatic ahb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] rd);
        logic r;
        @(posedge mclk_i);
        hsel   <= 1'h1;
        htrans <= 2'h2;
        haddr  <= {24'h0, a};
        hwrite <= w;
        do look(r, rd, 0); while (r !== 1'h1);
        hsel   <= 1'h0;
        htrans <= 2'h0;
        hwdata <= d;
        do look(r, rd, 0); while (r !== 1'h1);
    endtask : ahb
    task automatic mem(input logic [24:0] a, input logic w, input logic s);
        logic r;
        int   n;
        n = 0;
        @(posedge mclk_i);
        ra <= a;
        rw <= w;
        rs <= s;
        rv <= 1'h1;
        do look(r, q, 1); while (r !== 1'h1);
        rv <= 1'h0;
        do begin
            look(r, q, 2);
            n++;
        end while (r !== 1'h1 && n < 4000);
        check({31'h0, r}, 32'h1);
    endtask : mem
    always @(negedge mclk_i) begin
        if (!fcs_n) fl_addr = pa;
        if (rst_n_i) check({31'h0, fcs_n | scs_n}, 32'h1);
    end
    initial begin
        #100000;
        fail_count++;
        report_and_stop();
    end
    initial begin
        repeat (10) @(posedge mclk_i);
        rst_n_i <= 1'h1;
        ahb(1'h0, 8'h00, 32'h0, q);
        check(q, 32'h0007_3100);
        ahb(1'h0, 8'h04, 32'h0, q);
        check(q, 32'h0000_0F7F);
        ahb(1'h0, 8'h10, 32'h0, q);
        check(q, 32'h0);
        mem(25'h000_1236, 1'h0, 1'h1);
        check(q, 32'h5341_5341);
        check({12'h0, fl_addr}, 32'h0000_091B);
        ahb(1'h1, 8'h04, 32'h0000_0002, q);
        mem(25'h000_0888, 1'h0, 1'h0);
        check({12'h0, fl_addr}, 32'h0000_0444);
        $display("boot and flash read done");
        ahb(1'h1, 8'h08, 32'h50, q);
        ahb(1'h0, 8'h0C, 32'h0, q);
        check(q & 32'h6, 32'h6);
        ahb(1'h1, 8'h08, 32'h46, q);
        ahb(1'h0, 8'h0C, 32'h0, q);
        check(q & 32'h4, 32'h0);
        ahb(1'h1, 8'h00, 32'h0007_3181, q);
        ahb(1'h0, 8'h0C, 32'h0, q);
        check(q & 32'h8, 32'h8);
        check({31'h0, cke}, 32'h0);
        ahb(1'h1, 8'h00, 32'h0007_3101, q);
        mem(25'h000_0040, 1'h1, 1'h1);
        $display("clock and sdram setup done");
        rst_n_i <= 1'h0;
        repeat (2) @(posedge mclk_i);
        rst_n_i <= 1'h1;
        ahb(1'h0, 8'h00, 32'h0, q);
        check(q, 32'h0007_3100);
        $display("second reset done");
        report_and_stop();
    end
endmodule : fsmp_port_tb
